// *** inc/epr_pkg.sv ***
// shared constants and types of the exception priority resolver
// assumes a single core clock domain and the plain register port of epr_top
package epr_pkg;

  // ***********************************************
  // sizes and types
  // ***********************************************
  localparam int unsigned NUM_EXC = 32;
  localparam int unsigned NUM_IRQ = 8;
  typedef logic [4:0] epr_num_t;
  typedef logic [3:0] epr_lvl_t;
  typedef logic [2:0] epr_pri_t;
  typedef logic [7:0] epr_addr_t;

  // ***********************************************
  // exception numbers
  // ***********************************************
  localparam epr_num_t EXC_RESET  = 5'h01;
  localparam epr_num_t EXC_NMI    = 5'h02;
  localparam epr_num_t EXC_HARD   = 5'h03;
  localparam epr_num_t EXC_MEM    = 5'h04;
  localparam epr_num_t EXC_BUS    = 5'h05;
  localparam epr_num_t EXC_USAGE  = 5'h06;
  localparam epr_num_t EXC_SVC    = 5'h0b;
  localparam epr_num_t EXC_DEBUG  = 5'h0c;
  localparam epr_num_t EXC_PENDABLE_SERVICE_REQUEST = 5'h0e;
  localparam epr_num_t EXC_TICK   = 5'h0f;
  localparam epr_num_t EXC_IRQ0   = 5'h10;
  // numbers 1..6, 11, 12, 14, 15 and 16..23; 0, 7..10, 13 are reserved
  localparam logic [NUM_EXC-1:0] EXC_IMPL = 32'h00ffd87e;

  // ***********************************************
  // effective levels: lower wins; -3,-2,-1 map to 0,1,2
  // ***********************************************
  localparam epr_lvl_t LVL_RESET    = 4'h0;
  localparam epr_lvl_t LVL_NMI      = 4'h1;
  localparam epr_lvl_t LVL_HARD     = 4'h2;
  localparam epr_lvl_t LVL_CFG_BASE = 4'h3;
  localparam epr_lvl_t LVL_THREAD   = 4'hf;

  // ***********************************************
  // priority field inside each byte
  // ***********************************************
  localparam int unsigned PRI_HI = 7;
  localparam int unsigned PRI_LO = 5;

  // ***********************************************
  // register offsets and reset values
  // ***********************************************
  localparam epr_addr_t REG_FAULT_EN  = 8'h00;
  localparam epr_addr_t REG_SYS_PRI_A = 8'h04;
  localparam epr_addr_t REG_SYS_PRI_B = 8'h08;
  localparam epr_addr_t REG_IRQ_PRI_A = 8'h0c;
  localparam epr_addr_t REG_IRQ_PRI_B = 8'h10;
  localparam epr_addr_t REG_IRQ_EN    = 8'h14;
  localparam epr_addr_t REG_PEND      = 8'h18;
  localparam epr_addr_t REG_STATUS    = 8'h1c;
  localparam logic [2:0]         RST_FAULT_EN = 3'h0;
  localparam epr_pri_t           RST_PRI      = 3'h0;
  localparam logic [NUM_IRQ-1:0] RST_IRQ_EN   = 8'h00;
  localparam logic [NUM_EXC-1:0] RST_PEND     = 32'h00000002;
  // status fields
  localparam int unsigned STAT_WIN_LO = 8;
  localparam int unsigned STAT_FAULT  = 16;

endpackage : epr_pkg

// *** inc/epr_cand_if.sv ***
// candidate set and winner between epr_top and epr_arbiter
// assumes epr_pkg is compiled first
interface epr_cand_if;
  import epr_pkg::*;
  logic     [NUM_EXC-1:0] req;
  epr_lvl_t [NUM_EXC-1:0] lvl;
  logic                   win_valid;
  epr_num_t               win_num;
  epr_lvl_t               win_lvl;
  modport src (output req, output lvl, input win_valid, input win_num, input win_lvl);
  modport arb (input req, input lvl, output win_valid, output win_num, output win_lvl);
endinterface : epr_cand_if

// *** hdl/epr_sync.sv ***
// three-stage synchroniser for pin inputs
// assumes inputs are asynchronous to ref_clk; output moves once stages two and three agree
module epr_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } epr_sync_st_t;

  epr_sync_st_t st;
  epr_sync_st_t next_st;

  always_comb
  begin
    next_st        = st;
    next_st.s1     = async_in;
    next_st.s2     = st.s1;
    next_st.s3     = st.s2;
    // s1 feeds only s2; a bit moves only where s2 and s3 agree
    next_st.stable = (st.s2 & st.s3) | (st.stable & (st.s2 ^ st.s3));
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_out = st.stable;

endmodule : epr_sync

// *** hdl/epr_arbiter.sv ***
// picks the lowest level candidate, lowest number on a tie
// assumes every candidate level is below LVL_THREAD
module epr_arbiter (
  epr_cand_if.arb cand
);
  import epr_pkg::*;

  always_comb
  begin
    cand.win_valid = 1'b0;
    cand.win_num   = '0;
    cand.win_lvl   = LVL_THREAD;
    // descending scan with <= lets the smaller number take a tie
    for (int i = NUM_EXC - 1; i >= 0; i--)
    begin
      if (cand.req[i] && (cand.lvl[i] <= cand.win_lvl))
      begin
        cand.win_valid = 1'b1;
        cand.win_num   = epr_num_t'(i);
        cand.win_lvl   = cand.lvl[i];
      end
    end
  end

endmodule : epr_arbiter

// *** hdl/epr_top.sv ***
// exception recognition and priority resolution for the core
// assumes one core clock ref_clk, core events as one-cycle pulses on ref_clk,
// pins asynchronous, and a core that answers stack and unstack requests
//
// Overview of operation
// - of several pending requests only the highest effective priority is taken
// - reset is number 1 at level -3; nmi is number 2 at level -2
// - hard fault number 3 at -1 catches faults blocked by priority or disabled
// - memory, bus and usage faults have enables; disabled ones become hard fault
// - execute-never fetch raises memory management, number 4; no protection unit source
// - fault-region access raises bus fault, number 5, configurable priority
// - undefined or faulty instruction raises usage fault, number 6, configurable
// - supervisor call instruction raises number 11, configurable priority
// - debug monitor is number 12, taken only while not faulting
// - pendable service request is 14, system tick timer is 15, both configurable
// - pin and peripheral interrupts start at 16; 7 to 10 and 13 reserved
// - interrupt priorities from interrupt registers, the other configurable ones from system fields; reset, nmi and hard fault are fixed
// - on the 8-bit scale 0 to 255, lower value means higher priority
// - equal priority goes to the smaller exception number
// - each configurable priority keeps only 3 significant bits
// - those bits sit at [7:5]; the lower five bits read zero
// - on acceptance save state and branch, except reset which branches at once; on handler exit restore state
module epr_top (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire epr_pkg::epr_addr_t            reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  input  wire logic                          nmi_pin,
  input  wire logic [epr_pkg::NUM_IRQ-1:0]   irq_pin,
  input  wire logic                          watchdog_nmi,
  input  wire logic                          watchdog_reset,
  input  wire logic                          software_reset_request,
  input  wire logic                          fetch_execute_never,
  input  wire logic                          bus_fault_access,
  input  wire logic                          usage_fault_event,
  input  wire logic                          svc_exec,
  input  wire logic                          system_tick_event,
  input  wire logic                          debug_monitor_event,
  input  wire logic                          stack_done,
  input  wire logic                          unstack_done,
  input  wire logic                          handler_exit,
  output logic                               stack_start,
  output logic                               handler_branch,
  output epr_pkg::epr_num_t                  handler_number,
  output logic                               unstack_start,
  output epr_pkg::epr_num_t                  active_number
);
  import epr_pkg::*;

  // ***********************************************
  // state
  // ***********************************************
  typedef enum logic [1:0] {ST_RUN, ST_STACK, ST_UNSTACK} epr_state_t;

  typedef struct packed {
    epr_state_t                  state;
    logic [2:0]                  fault_en;
    epr_pri_t [NUM_EXC-1:0]      pri;
    logic [NUM_IRQ-1:0]          irq_en;
    logic [NUM_EXC-1:0]          pend;
    logic [NUM_EXC-1:0]          active;
    logic                        nmi_last;
    epr_num_t                    target;
    logic [31:0]                 rdata;
    logic                        stack_start;
    logic                        handler_branch;
    epr_num_t                    handler_number;
    logic                        unstack_start;
    epr_num_t                    active_number;
  } epr_top_st_t;

  epr_top_st_t st;
  epr_top_st_t next_st;

  logic [NUM_IRQ-1:0] irq_sync;
  logic               nmi_sync;
  logic               faulting;
  epr_lvl_t           cur_lvl;
  epr_lvl_t [NUM_EXC-1:0] lvl;

  epr_cand_if pend_c ();
  epr_cand_if act_c ();

  // ***********************************************
  // pin synchronisers and arbiters
  // ***********************************************
  epr_sync #(
    .W (NUM_IRQ + 1)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({nmi_pin, irq_pin}),
    .sync_out ({nmi_sync, irq_sync})
  );

  // one arbiter picks what to take, the other finds the running level
  epr_arbiter u_pend_arb (
    .cand (pend_c.arb)
  );

  epr_arbiter u_act_arb (
    .cand (act_c.arb)
  );

  // ***********************************************
  // effective levels
  // ***********************************************
  always_comb
  begin
    for (int n = 0; n < NUM_EXC; n++)
    begin
      // 3-bit field lifted above the fixed levels
      lvl[n] = epr_lvl_t'(LVL_CFG_BASE + epr_lvl_t'(st.pri[n]));
    end
    lvl[EXC_RESET] = LVL_RESET;
    lvl[EXC_NMI]   = LVL_NMI;
    lvl[EXC_HARD]  = LVL_HARD;
  end

  assign faulting = |st.active[EXC_USAGE:EXC_HARD];
  assign cur_lvl  = act_c.win_valid ? act_c.win_lvl : LVL_THREAD;

  always_comb
  begin
    pend_c.req = st.pend & EXC_IMPL;
    for (int k = 0; k < NUM_IRQ; k++)
    begin
      pend_c.req[EXC_IRQ0 + k] = st.pend[EXC_IRQ0 + k] & st.irq_en[k];
    end
    pend_c.req[EXC_DEBUG] = st.pend[EXC_DEBUG] & ~faulting;
    pend_c.lvl = lvl;
    act_c.req  = st.active;
    act_c.lvl  = lvl;
  end

  // ***********************************************
  // byte lane owners of the priority registers
  // ***********************************************
  function automatic logic [5:0] epr_owner(input epr_addr_t a, input int unsigned k);
    logic [5:0] r;
    r = '0;
    unique case (a)
      REG_SYS_PRI_A:
        if (k < 3)
          r = {1'b1, epr_num_t'(EXC_MEM + k)};
      REG_SYS_PRI_B:
        unique case (k)
          0: r = {1'b1, EXC_SVC};
          1: r = {1'b1, EXC_DEBUG};
          2: r = {1'b1, EXC_PENDABLE_SERVICE_REQUEST};
          default: r = {1'b1, EXC_TICK};
        endcase
      REG_IRQ_PRI_A:
        r = {1'b1, epr_num_t'(EXC_IRQ0 + k)};
      REG_IRQ_PRI_B:
        r = {1'b1, epr_num_t'(EXC_IRQ0 + 4 + k)};
      default:
        r = '0;
    endcase
    return r;
  endfunction : epr_owner

  // ***********************************************
  // next state
  // ***********************************************
  always_comb
  begin
    logic [NUM_EXC-1:0] set_p;
    logic [NUM_EXC-1:0] clr_p;
    logic [5:0]         own;
    logic [2:0]         f_ev;
    epr_num_t           f_num;
    next_st                = st;
    set_p                  = '0;
    clr_p                  = '0;
    own                    = '0;
    f_num                  = EXC_MEM;
    f_ev                   = '0;
    next_st.stack_start    = 1'b0;
    next_st.handler_branch = 1'b0;
    next_st.unstack_start  = 1'b0;
    next_st.rdata          = '0;
    next_st.nmi_last       = nmi_sync;

    // event sources
    set_p[EXC_RESET]  = watchdog_reset | software_reset_request;
    set_p[EXC_NMI]    = watchdog_nmi | (nmi_sync & ~st.nmi_last);
    set_p[EXC_SVC]    = svc_exec;
    set_p[EXC_DEBUG]  = debug_monitor_event;
    set_p[EXC_TICK]   = system_tick_event;
    set_p[EXC_IRQ0 +: NUM_IRQ] = irq_sync;
    f_ev = {usage_fault_event, bus_fault_access, fetch_execute_never};
    for (int f = 0; f < 3; f++)
    begin
      f_num = epr_num_t'(EXC_MEM + f);
      if (f_ev[f])
      begin
        // disabled or blocked by a running handler of equal or lower level
        if (!st.fault_en[f] || (lvl[f_num] >= cur_lvl))
          set_p[EXC_HARD] = 1'b1;
        else
          set_p[f_num] = 1'b1;
      end
    end

    // register port
    if (reg_wr)
    begin
      unique case (reg_addr)
        REG_FAULT_EN: next_st.fault_en = reg_wdata[2:0];
        REG_IRQ_EN:   next_st.irq_en   = reg_wdata[NUM_IRQ-1:0];
        REG_PEND:
        begin
          set_p[EXC_PENDABLE_SERVICE_REQUEST] = set_p[EXC_PENDABLE_SERVICE_REQUEST] | reg_wdata[EXC_PENDABLE_SERVICE_REQUEST];
          set_p[EXC_DEBUG]  = set_p[EXC_DEBUG] | reg_wdata[EXC_DEBUG];
        end
        default:
          for (int k = 0; k < 4; k++)
          begin
            own = epr_owner(reg_addr, k);
            if (own[5])
              next_st.pri[own[4:0]] = reg_wdata[8*k+PRI_LO +: 3];
          end
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_FAULT_EN: next_st.rdata = {29'h0, st.fault_en};
        REG_IRQ_EN:   next_st.rdata = {24'h0, st.irq_en};
        REG_PEND:     next_st.rdata = st.pend;
        REG_STATUS:
        begin
          next_st.rdata[4:0] = st.active_number;
          next_st.rdata[STAT_WIN_LO +: 5] = pend_c.win_num;
          next_st.rdata[STAT_FAULT] = faulting;
        end
        default:
          for (int k = 0; k < 4; k++)
          begin
            own = epr_owner(reg_addr, k);
            if (own[5])
              next_st.rdata[8*k +: 8] = {st.pri[own[4:0]], 5'h00};
          end
      endcase
    end

    // acceptance and return
    unique case (st.state)
      ST_RUN:
        if (pend_c.win_valid && (pend_c.win_lvl < cur_lvl))
        begin
          if (pend_c.win_num == EXC_RESET)
          begin
            // reset discards all nesting and needs no saved state
            next_st.active         = '0;
            clr_p[EXC_RESET]       = 1'b1;
            next_st.handler_branch = 1'b1;
            next_st.handler_number = EXC_RESET;
            next_st.active_number  = EXC_RESET;
          end
          else
          begin
            next_st.target      = pend_c.win_num;
            next_st.stack_start = 1'b1;
            next_st.state       = ST_STACK;
          end
        end
        else if (handler_exit && act_c.win_valid)
        begin
          next_st.active[act_c.win_num] = 1'b0;
          next_st.unstack_start = 1'b1;
          next_st.state         = ST_UNSTACK;
        end
      ST_STACK:
        if (stack_done)
        begin
          clr_p[st.target]          = 1'b1;
          next_st.active[st.target] = 1'b1;
          next_st.handler_branch    = 1'b1;
          next_st.handler_number    = st.target;
          next_st.active_number     = st.target;
          next_st.state             = ST_RUN;
        end
      ST_UNSTACK:
        if (unstack_done)
        begin
          // level already dropped when the exit was taken
          next_st.active_number = act_c.win_valid ? act_c.win_num : '0;
          next_st.state         = ST_RUN;
        end
      default:
        next_st.state = ST_RUN;
    endcase

    // a new event wins over the clear of the same cycle
    next_st.pend = ((st.pend & ~clr_p) | set_p) & EXC_IMPL;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st          <= '0;
      st.state    <= ST_RUN;
      st.fault_en <= RST_FAULT_EN;
      st.pri      <= {NUM_EXC{RST_PRI}};
      st.irq_en   <= RST_IRQ_EN;
      st.pend     <= RST_PEND;
    end
    else
      st <= next_st;
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign reg_rdata      = st.rdata;
  assign stack_start    = st.stack_start;
  assign handler_branch = st.handler_branch;
  assign handler_number = st.handler_number;
  assign unstack_start  = st.unstack_start;
  assign active_number  = st.active_number;

endmodule : epr_top

// *** tb/epr_top_props.sv ***
// concurrent checks on the ports of epr_top
// assumes epr_pkg is compiled first; bound to every epr_top instance
module epr_top_props
  import epr_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst_n,
  input wire epr_addr_t reg_addr,
  input wire logic      reg_rd,
  input wire logic      [31:0] reg_rdata,
  input wire logic      stack_done,
  input wire logic      unstack_done,
  input wire logic      handler_exit,
  input wire logic      stack_start,
  input wire logic      handler_branch,
  input wire epr_num_t  handler_number,
  input wire logic      unstack_start,
  input wire epr_num_t  active_number
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************************
  // checks
  // ***********************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_reset_entry: assert property ($rose(rst_n) |=> handler_branch && handler_number == EXC_RESET)
    else $error("reset exception not entered after release");
  chk_stack_branch: assert property (stack_done |=> handler_branch)
    else $error("no branch after state saved");
  chk_stack_quiet: assert property (stack_start |=> !stack_start && !handler_branch)
    else $error("stack request not a lone pulse");
  chk_exit_unstack: assert property (handler_exit |=> unstack_start)
    else $error("exit did not ask for restore");
  chk_restore_active: assert property (unstack_done |=> active_number != $past(active_number))
    else $error("active number kept after restore");
  chk_branch_active: assert property (handler_branch |-> active_number == handler_number)
    else $error("active number differs from branch");
  chk_no_reserved: assert property (handler_branch |-> EXC_IMPL[handler_number])
    else $error("branch to reserved number");
  chk_pri_low_zero: assert property (reg_rd && reg_addr inside {[REG_SYS_PRI_A:REG_IRQ_PRI_B]}
    |=> (reg_rdata & 32'h1f1f1f1f) == 32'h0)
    else $error("low priority bits not zero");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule : epr_top_props

bind epr_top epr_top_props u_props (
  .ref_clk        (ref_clk),
  .rst_n          (rst_n),
  .reg_addr       (reg_addr),
  .reg_rd         (reg_rd),
  .reg_rdata      (reg_rdata),
  .stack_done     (stack_done),
  .unstack_done   (unstack_done),
  .handler_exit   (handler_exit),
  .stack_start    (stack_start),
  .handler_branch (handler_branch),
  .handler_number (handler_number),
  .unstack_start  (unstack_start),
  .active_number  (active_number)
);

// *** tb/epr_core_model.sv ***
// behavioural core: saves and restores state on request
// assumes one-cycle request pulses on ref_clk; slow stretches each answer
module epr_core_model (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic stack_start,
  input  wire logic unstack_start,
  input  wire logic slow,
  output logic      stack_done,
  output logic      unstack_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int scnt;
  int ucnt;
  // one done pulse per request, never unasked
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scnt <= 0;
      ucnt <= 0;
      stack_done <= 1'b0;
      unstack_done <= 1'b0;
    end
    else
    begin
      stack_done <= (scnt == 1);
      unstack_done <= (ucnt == 1);
      scnt <= stack_start ? (slow ? 6 : 1) : (scnt > 0 ? scnt - 1 : 0);
      ucnt <= unstack_start ? (slow ? 6 : 1) : (ucnt > 0 ? ucnt - 1 : 0);
    end
  end
endmodule : epr_core_model

// *** tb/epr_top_tb.sv ***
// self-checking bench of epr_top against a queue model of pending exceptions
// assumes epr_top, epr_core_model and the bound checker are compiled
module epr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import epr_pkg::*;
  logic               ref_clk, rst_n, reg_wr, reg_rd, nmi_pin, handler_exit, slow;
  epr_addr_t          reg_addr;
  logic [31:0]        reg_wdata, reg_rdata, w;
  logic [NUM_IRQ-1:0] irq_pin;
  logic [8:0]         ev;
  logic               stack_done, unstack_done, stack_start, handler_branch, unstack_start;
  epr_num_t           handler_number, active_number;
  int                 bad_count, compares, seed, m;
  int                 pri[32];
  int                 q[$];

  epr_top dut (
    .ref_clk (ref_clk), .rst_n (rst_n), .reg_addr (reg_addr), .reg_wdata (reg_wdata),
    .reg_wr (reg_wr), .reg_rd (reg_rd), .reg_rdata (reg_rdata), .nmi_pin (nmi_pin), .irq_pin (irq_pin),
    .svc_exec (ev[0]), .system_tick_event (ev[1]), .debug_monitor_event (ev[2]),
    .fetch_execute_never (ev[3]), .bus_fault_access (ev[4]), .usage_fault_event (ev[5]),
    .watchdog_nmi (ev[6]), .watchdog_reset (ev[7]), .software_reset_request (ev[8]),
    .stack_done (stack_done), .unstack_done (unstack_done), .handler_exit (handler_exit),
    .stack_start (stack_start), .handler_branch (handler_branch), .handler_number (handler_number),
    .unstack_start (unstack_start), .active_number (active_number)
  );
  epr_core_model core (
    .ref_clk (ref_clk), .rst_n (rst_n), .stack_start (stack_start), .unstack_start (unstack_start),
    .slow (slow), .stack_done (stack_done), .unstack_done (unstack_done)
  );

  // ***********************************************
  // tasks
  // ***********************************************
  task automatic final_report;
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input epr_addr_t a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input epr_addr_t a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask : rd

  task automatic pulse(input logic [8:0] msk);
    @(posedge ref_clk);
    ev <= msk;
    @(posedge ref_clk);
    ev <= '0;
  endtask : pulse

  // bounded wait; a missing branch shows as a mismatch
  task automatic take(input int n);
    int t;
    t = 0;
    do
    begin
      @(negedge ref_clk);
      t++;
    end
    while (handler_branch !== 1'b1 && t < 300);
    chk({handler_branch, 21'h0, active_number, handler_number}, {1'b1, 21'h0, 5'(n), 5'(n)});
    // hand back on a rising edge so callers drive inputs there
    @(posedge ref_clk);
  endtask : take

  task automatic leave;
    @(posedge ref_clk);
    handler_exit <= 1'b1;
    @(posedge ref_clk);
    handler_exit <= 1'b0;
  endtask : leave

  // ***********************************************
  // clock, watchdog, scenarios
  // ***********************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial
  begin
    #(50 * 40000);
    bad_count++;
    final_report;
  end

  initial
  begin
    {reg_wr, reg_rd, nmi_pin, handler_exit, slow} = '0;
    ev = '0;
    irq_pin = '0;
    reg_addr = '0;
    reg_wdata = '0;
    rst_n = 1'b0;
    seed = 32'h3ea4596f;
    bad_count = 0;
    compares = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset handler holds no active bit, so no exit follows it
    take(EXC_RESET);
    rd(REG_FAULT_EN, 32'h0);
    rd(REG_SYS_PRI_A, 32'h0);
    rd(REG_IRQ_EN, 32'h0);
    rd(8'h40, 32'h0);
    wr(REG_IRQ_EN, 32'hff);
    for (int r = 0; r < 6; r++)
    begin
      w = $random(seed);
      wr(REG_SYS_PRI_B, w);
      rd(REG_SYS_PRI_B, w & 32'he0e0e0e0);
      pri[11] = w[7:5];
      pri[12] = w[15:13];
      pri[14] = w[23:21];
      pri[15] = w[31:29];
      w = $random(seed);
      wr(REG_IRQ_PRI_A, w);
      for (int k = 0; k < 4; k++) pri[16 + k] = w[8 * k + 5 +: 3];
      w = $random(seed);
      wr(REG_IRQ_PRI_B, w);
      for (int k = 0; k < 4; k++) pri[20 + k] = w[8 * k + 5 +: 3];
      slow <= r[0];
      // nmi blocks every configurable level while the set builds up
      if (r[0])
        pulse(9'h040);
      else
        nmi_pin <= 1'b1;
      take(EXC_NMI);
      nmi_pin <= 1'b0;
      pulse(9'h007);
      wr(REG_PEND, 32'h4000);
      w = $random(seed);
      irq_pin <= w[7:0];
      repeat (8) @(posedge ref_clk);
      irq_pin <= '0;
      q = {11, 12, 14, 15};
      for (int k = 0; k < 8; k++)
        if (w[k])
          q.push_back(16 + k);
      leave;
      while (q.size() > 0)
      begin
        m = 0;
        for (int j = 1; j < q.size(); j++)
          if (pri[q[j]] * 32 + q[j] < pri[q[m]] * 32 + q[m])
            m = j;
        take(q[m]);
        q.delete(m);
        leave;
      end
    end
    wr(REG_SYS_PRI_A, 32'hffffffff);
    rd(REG_SYS_PRI_A, 32'h00e0e0e0);
    wr(REG_SYS_PRI_B, 32'h0);
    for (int f = 0; f < 3; f++)
    begin
      wr(REG_FAULT_EN, 32'h0);
      pulse(9'(9'h008 << f));
      take(EXC_HARD);
      leave;
      wr(REG_FAULT_EN, 32'(1 << f));
      pulse(9'(9'h008 << f));
      take(4 + f);
      wr(REG_PEND, 32'h1000);
      rd(REG_PEND, 32'h00001000);
      rd(REG_STATUS, 32'h00010004 + 32'(f));
      repeat (10)
      begin
        @(negedge ref_clk);
        chk(32'(handler_branch), 32'h0);
      end
      leave;
      take(EXC_DEBUG);
      leave;
    end
    pulse(9'h080);
    take(EXC_RESET);
    pulse(9'h100);
    take(EXC_RESET);
    final_report;
  end
endmodule : epr_top_tb
